// *** rtl/acsv_top.sv ***
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Contract
// - class indication while member alarm active/latched
// - any-class summary over all six classes
// - warning summary over first two classes
// - shutdown summary over classes three to six
// - centralized summary excludes first class only
// - new-alarm sets on trigger until acknowledged
// - horn on trigger until reset time elapses
// - relay variables mirror driving equation states
// - sixteen flags in two index ranges
// - flag outputs feed back to equations
// - three exclusive sync mode indications
// - external acknowledge variable selects remote ack
// - automatic and manual mode request variables
// - keypad lock indication while locked
// - alarm indications selectable by every equation
// - relay one combined with not-ready condition
module acsv_top
  import acsv_pkg::*;
#(
  parameter int unsigned NUM_CLASSES = ACSV_NUM_CLASSES,
  parameter int unsigned NUM_FLAGS = ACSV_NUM_FLAGS,
  parameter int unsigned TICK_CYC = ACSV_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // alarm sources, per class
  input wire logic [NUM_CLASSES-1:0] class_active,
  input wire logic [NUM_CLASSES-1:0] class_latched,
  input wire logic [NUM_CLASSES-1:0] class_trigger,
  input wire logic panel_ack,
  input wire logic remote_ack,
  // equation evaluator results
  input wire logic [NUM_FLAGS-1:0] flag_eq,
  input wire logic [ACSV_NUM_RELAYS-1:0] relay_eq,
  input wire logic not_ready,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status vector to equations
  output logic [NUM_CLASSES-1:0] alarm_class,
  output logic all_classes,
  output logic warning_alarm,
  output logic shutdown_alarm,
  output logic centralized_alarm,
  output logic new_alarm,
  output logic horn,
  output logic [NUM_FLAGS-1:0] internal_flag_output,
  output logic [ACSV_NUM_RELAYS-1:0] relay_equation_state,
  output logic relay1_drive,
  output logic check_sync_active,
  output logic permissive_sync_active,
  output logic run_sync_active,
  output logic remote_ack_request,
  output logic automatic_mode_request,
  output logic manual_mode_request,
  output logic keypad_lock_active,
  // interrupt
  output logic irq
);
  initial begin
    if (NUM_CLASSES != ACSV_NUM_CLASSES)
      $error("acsv_top: summaries are defined for six classes");
    if (NUM_FLAGS != ACSV_NUM_FLAGS)
      $error("acsv_top: flag layout needs sixteen flags");
    if (TICK_CYC < 2)
      $error("acsv_top: tick divider needs at least two cycles");
    if ((ACSV_WARN_MASK & ACSV_SHUT_MASK) != 6'h00)
      $error("acsv_top: warning and shutdown classes overlap");
    if ((ACSV_WARN_MASK | ACSV_SHUT_MASK) != 6'h3F)
      $error("acsv_top: warning and shutdown must cover all classes");
    if (ACSV_RLY_ONE >= ACSV_NUM_RELAYS)
      $error("acsv_top: relay one slot outside relay vector");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_CLASSES-1:0] cls;
    logic all_c;
    logic warn;
    logic shut;
    logic cent;
    logic newa;
    logic horn;
    logic [15:0] horn_ms;
    logic [15:0] horn_time;
    logic [NUM_FLAGS-1:0] flags;
    logic [ACSV_NUM_RELAYS-1:0] rly;
    logic r1;
    acsv_sync_t sync;
    logic chk;
    logic prm;
    logic run;
    logic rack;
    logic autor;
    logic manr;
    logic klock;
    logic [ACSV_NUM_IRQ-1:0] ist;
    logic [ACSV_NUM_IRQ-1:0] imsk;
    logic irq;
    logic ack;
    logic back;
    logic [31:0] dat;
  } acsv_state_t;

  acsv_state_t s_q, s_d;

  acsv_tick_if tk();

  acsv_tick_div #(
    .DIV(TICK_CYC)
  ) u_div (
    .clk(clk),
    .arst_n(arst_n),
    .t(tk)
  );

  logic [NUM_CLASSES-1:0] cls_now;
  logic trig;
  logic ack_evt;
  logic req;
  logic wr;
  logic rd;
  logic [31:0] wmask;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic horn_done;

  // ==========================================================
  // combinational evaluation
  always_comb begin
    s_d = s_q;
    cls_now = class_active | class_latched;
    trig = |class_trigger;
    // acknowledgement source chosen by the remote-ack variable
    ack_evt = s_q.rack ? remote_ack : panel_ack;
    ack_evt = ack_evt | s_q.ack;
    // the raised bus ack blocks a second take of the same request
    req = wb_cyc_i & wb_stb_i & ~s_q.back;
    wr = req & wb_we_i;
    rd = req & ~wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    horn_done = 1'b0;

    // ==========================================================
    // class and summary indications are registered in this one update
    s_d.cls = cls_now;
    s_d.all_c = |cls_now;
    s_d.warn = |(cls_now & ACSV_WARN_MASK);
    s_d.shut = |(cls_now & ACSV_SHUT_MASK);
    s_d.cent = |(cls_now & ACSV_CENT_MASK);

    // ==========================================================
    // trigger wins over a simultaneous acknowledge
    if (trig) begin
      s_d.newa = 1'b1;
    end else if (ack_evt) begin
      s_d.newa = 1'b0;
    end

    // ==========================================================
    // horn: restart on every trigger, stop on expiry
    if (trig) begin
      // a zero reset time leaves the horn silent
      if (s_q.horn_time == 16'h0000) begin
        s_d.horn = 1'b0;
      end else begin
        s_d.horn = 1'b1;
      end
      s_d.horn_ms = s_q.horn_time;
    end else if (s_q.horn && tk.tick) begin
      if (s_q.horn_ms <= 16'h0001) begin
        s_d.horn = 1'b0;
        s_d.horn_ms = '0;
        horn_done = 1'b1;
      end else begin
        s_d.horn_ms = s_q.horn_ms - 16'h0001;
      end
    end

    // ==========================================================
    // flags are registered and fed back to the evaluator
    s_d.flags = flag_eq;
    s_d.rly = relay_eq;
    // relay one energises only if its equation holds and unit ready
    s_d.r1 = relay_eq[ACSV_RLY_ONE] & ~not_ready;

    // one-hot sync indications decoded from the stored mode
    s_d.chk = 1'b0;
    s_d.prm = 1'b0;
    s_d.run = 1'b0;
    unique case (s_q.sync)
      ACSV_SYNC_CHECK: begin
        s_d.chk = 1'b1;
      end
      ACSV_SYNC_PERM: begin
        s_d.prm = 1'b1;
      end
      ACSV_SYNC_RUN: begin
        s_d.run = 1'b1;
      end
      default: begin
      end
    endcase

    // ==========================================================
    // sticky events: set wins over read clear
    if (rd && wb_adr_i == ACSV_REG_IRQ) begin
      s_d.ist = '0;
    end
    if (trig) begin
      s_d.ist[ACSV_I_NEW] = 1'b1;
    end
    if (horn_done) begin
      s_d.ist[ACSV_I_HORN_END] = 1'b1;
    end
    if (ack_evt && s_q.newa) begin
      s_d.ist[ACSV_I_ACK] = 1'b1;
    end
    s_d.irq = |(s_d.ist & s_d.imsk);

    // ==========================================================
    // register views and writes
    ctrl_rd = '0;
    ctrl_rd[ACSV_C_SYNC +: 2] = s_q.sync;
    ctrl_rd[ACSV_C_RACK] = s_q.rack;
    ctrl_rd[ACSV_C_AUTO] = s_q.autor;
    ctrl_rd[ACSV_C_MAN] = s_q.manr;
    ctrl_rd[ACSV_C_KLOCK] = s_q.klock;
    stat_rd = '0;
    stat_rd[NUM_CLASSES-1:0] = s_q.cls;
    stat_rd[NUM_CLASSES +: 6] = {s_q.horn, s_q.newa, s_q.cent,
                                 s_q.shut, s_q.warn, s_q.all_c};
    s_d.ack = 1'b0;
    if (wr) begin
      unique case (wb_adr_i)
        ACSV_REG_CTRL: begin
          if (wb_sel_i[0]) begin
            if (wb_dat_i[ACSV_C_SYNC +: 2] != 2'b11) begin
              s_d.sync = acsv_sync_t'(wb_dat_i[ACSV_C_SYNC +: 2]);
            end
            s_d.rack = wb_dat_i[ACSV_C_RACK];
            s_d.autor = wb_dat_i[ACSV_C_AUTO];
            s_d.manr = wb_dat_i[ACSV_C_MAN];
            s_d.klock = wb_dat_i[ACSV_C_KLOCK];
            s_d.ack = wb_dat_i[ACSV_C_ACK];
          end
        end
        ACSV_REG_HORN: begin
          s_d.horn_time = (s_q.horn_time & ~wmask[15:0])
                        | (wb_dat_i[15:0] & wmask[15:0]);
        end
        ACSV_REG_MASK: begin
          if (wb_sel_i[0]) s_d.imsk = wb_dat_i[ACSV_NUM_IRQ-1:0];
        end
        default: begin
        end
      endcase
    end
    // ack stands one cycle, then falls while the master releases
    s_d.back = req;

    // ==========================================================
    // bus answer one cycle after the request; unmapped reads zero
    s_d.dat = '0;
    if (rd) begin
      unique case (wb_adr_i)
        ACSV_REG_CTRL: begin
          s_d.dat = ctrl_rd;
        end
        ACSV_REG_HORN: begin
          s_d.dat = {16'h0000, s_q.horn_time};
        end
        ACSV_REG_STAT: begin
          s_d.dat = stat_rd;
        end
        ACSV_REG_IRQ: begin
          s_d.dat = {29'h0000_0000, s_q.ist};
        end
        ACSV_REG_MASK: begin
          s_d.dat = {29'h0000_0000, s_q.imsk};
        end
        default: begin
          s_d.dat = '0;
        end
      endcase
    end
    // a fresh manual request withdraws the automatic request
    if (s_d.manr && !s_q.manr) begin
      s_d.autor = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.horn_time <= ACSV_HORN_DEF_MS;
      s_q.sync <= ACSV_SYNC_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign wb_ack_o = s_q.back;
  assign wb_dat_o = s_q.dat;
  assign alarm_class = s_q.cls;
  assign all_classes = s_q.all_c;
  assign warning_alarm = s_q.warn;
  assign shutdown_alarm = s_q.shut;
  assign centralized_alarm = s_q.cent;
  assign new_alarm = s_q.newa;
  assign horn = s_q.horn;
  assign internal_flag_output = s_q.flags;
  assign relay_equation_state = s_q.rly;
  assign relay1_drive = s_q.r1;
  assign check_sync_active = s_q.chk;
  assign permissive_sync_active = s_q.prm;
  assign run_sync_active = s_q.run;
  assign remote_ack_request = s_q.rack;
  assign automatic_mode_request = s_q.autor;
  assign manual_mode_request = s_q.manr;
  assign keypad_lock_active = s_q.klock;
  assign irq = s_q.irq;
endmodule

// *** rtl/acsv_pkg.sv ***
package acsv_pkg;
  // class count and class ordering (first class is index 0)
  localparam int unsigned ACSV_NUM_CLASSES = 6;
  localparam int unsigned ACSV_NUM_FLAGS = 16;
  localparam int unsigned ACSV_FLAGS_LO = 8;
  localparam int unsigned ACSV_NUM_RELAYS = 5;
  localparam int unsigned ACSV_NUM_SIG = 16;

  // relay variable slots: relays 1..4 then relay 6 (slot 54 is reserved)
  localparam int unsigned ACSV_RLY_ONE = 0;

  // class groupings for the summaries
  localparam logic [5:0] ACSV_WARN_MASK = 6'h03;
  localparam logic [5:0] ACSV_SHUT_MASK = 6'h3C;
  localparam logic [5:0] ACSV_CENT_MASK = 6'h3E;

  // horn reset time
  localparam int unsigned ACSV_CLK_HZ = 100_000_000;
  localparam int unsigned ACSV_HORN_TICK_US = 1000;
  localparam int unsigned ACSV_TICK_CYC = ACSV_CLK_HZ / 1_000_000
    * ACSV_HORN_TICK_US;
  localparam logic [15:0] ACSV_HORN_DEF_MS = 16'h00B4;

  // sync mode encoding
  typedef enum logic [1:0] {
    ACSV_SYNC_CHECK = 2'b00,
    ACSV_SYNC_PERM = 2'b01,
    ACSV_SYNC_RUN = 2'b10
  } acsv_sync_t;

  // register byte offsets
  localparam logic [7:0] ACSV_REG_CTRL = 8'h00;
  localparam logic [7:0] ACSV_REG_HORN = 8'h04;
  localparam logic [7:0] ACSV_REG_STAT = 8'h08;
  localparam logic [7:0] ACSV_REG_IRQ = 8'h0C;
  localparam logic [7:0] ACSV_REG_MASK = 8'h10;

  // ctrl field positions
  localparam int unsigned ACSV_C_SYNC = 0;
  localparam int unsigned ACSV_C_RACK = 2;
  localparam int unsigned ACSV_C_AUTO = 3;
  localparam int unsigned ACSV_C_MAN = 4;
  localparam int unsigned ACSV_C_KLOCK = 5;
  localparam int unsigned ACSV_C_ACK = 6;

  // interrupt bits
  localparam int unsigned ACSV_I_NEW = 0;
  localparam int unsigned ACSV_I_HORN_END = 1;
  localparam int unsigned ACSV_I_ACK = 2;
  localparam int unsigned ACSV_NUM_IRQ = 3;
endpackage

// *** rtl/acsv_if.sv ***
`timescale 1ns/100ps
interface acsv_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** rtl/acsv_tick_div.sv ***
`timescale 1ns/100ps
module acsv_tick_div
  import acsv_pkg::*;
#(
  parameter int unsigned DIV = ACSV_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // enable pulse out
  acsv_tick_if.src t
);
  initial begin
    if (DIV < 2) $error("acsv_tick_div: DIV must be at least 2");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } acsv_div_t;

  acsv_div_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(DIV - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.tick = s_q.tick;
endmodule

// *** verif/acsv_top_sva.sv ***
`timescale 1ns/100ps
module acsv_top_sva
  import acsv_pkg::*;
#(
  parameter int unsigned NUM_CLASSES = ACSV_NUM_CLASSES,
  parameter int unsigned NUM_FLAGS = ACSV_NUM_FLAGS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // inputs
  input wire logic [NUM_CLASSES-1:0] class_active,
  input wire logic [NUM_CLASSES-1:0] class_latched,
  input wire logic [NUM_CLASSES-1:0] class_trigger,
  input wire logic panel_ack,
  input wire logic remote_ack,
  input wire logic [NUM_FLAGS-1:0] flag_eq,
  input wire logic [ACSV_NUM_RELAYS-1:0] relay_eq,
  input wire logic not_ready,
  input wire logic wb_stb_i,
  // status vector
  input wire logic [NUM_CLASSES-1:0] alarm_class,
  input wire logic all_classes,
  input wire logic warning_alarm,
  input wire logic shutdown_alarm,
  input wire logic centralized_alarm,
  input wire logic new_alarm,
  input wire logic horn,
  input wire logic [NUM_FLAGS-1:0] internal_flag_output,
  input wire logic [ACSV_NUM_RELAYS-1:0] relay_equation_state,
  input wire logic relay1_drive,
  input wire logic check_sync_active,
  input wire logic permissive_sync_active,
  input wire logic run_sync_active
);
  // ==========
  // helpers
  logic up_q;
  logic [5:0] src;
  // first edge after reset would compare against reset-time stimulus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 1'h0;
    end else begin
      up_q <= 1'h1;
    end
  end
  assign src = 6'(class_active | class_latched);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence trig_s;
    up_q && (|class_trigger);
  endsequence
  // a bus write may carry the software acknowledge
  sequence hold_s;
    new_alarm && !panel_ack && !remote_ack && !wb_stb_i;
  endsequence
  // ==========
  // assertions
  class_map_a: assert property (up_q |-> alarm_class == $past(src))
    else $error("class indication wrong");
  sum_all_a: assert property (up_q |-> all_classes == (|$past(src)))
    else $error("any-class summary wrong");
  sum_warn_a: assert property (up_q |->
    warning_alarm == (|($past(src) & ACSV_WARN_MASK)))
    else $error("warning summary wrong");
  sum_shut_a: assert property (up_q |->
    shutdown_alarm == (|($past(src) & ACSV_SHUT_MASK)))
    else $error("shutdown summary wrong");
  sum_cent_a: assert property (up_q |->
    centralized_alarm == (|($past(src) & ACSV_CENT_MASK)))
    else $error("centralized summary wrong");
  new_set_a: assert property (trig_s |=> new_alarm && horn)
    else $error("trigger did not set new alarm and horn");
  new_hold_a: assert property (hold_s |=> new_alarm)
    else $error("new alarm cleared without ack");
  horn_cause_a: assert property (up_q && $rose(horn) |->
    $past(|class_trigger))
    else $error("horn rose without trigger");
  relay_map_a: assert property (up_q |-> relay_equation_state ==
    $past(relay_eq) && relay1_drive == $past(relay_eq[0] && !not_ready))
    else $error("relay state wrong");
  flag_map_a: assert property (up_q |->
    internal_flag_output == $past(flag_eq))
    else $error("flag output wrong");
  sync_one_a: assert property (up_q |-> $onehot({check_sync_active,
    permissive_sync_active, run_sync_active}))
    else $error("sync indications not one-hot");
  sum_sync_a: assert property (all_classes == (|alarm_class))
    else $error("summary out of step with classes");
endmodule

bind acsv_top acsv_top_sva #(.NUM_CLASSES(NUM_CLASSES),
  .NUM_FLAGS(NUM_FLAGS)) sva (.*);

// *** verif/acsv_eq_model.sv ***
`timescale 1ns/100ps
module acsv_eq_model
  import acsv_pkg::*;
(
  // status read back
  input wire logic [5:0] alarm_class,
  input wire logic [15:0] internal_flag_output,
  // free equation terms
  input wire logic [15:0] user_flags,
  input wire logic [4:0] user_relays,
  // equation results
  output logic [15:0] flag_eq,
  output logic [ACSV_NUM_RELAYS-1:0] relay_eq
);
  // ==========
  // flag 1 reads the first class, flag 2 chains flag 1
  assign flag_eq = {user_flags[15:2], internal_flag_output[0],
    alarm_class[0]};
  assign relay_eq = user_relays;
endmodule

// *** verif/acsv_test.sv ***
`timescale 1ns/100ps
module acsv_test
  import acsv_pkg::*;
;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [5:0] class_active = 6'h00, class_latched = 6'h00;
  logic [5:0] class_trigger = 6'h00, alarm_class;
  logic panel_ack = 1'h0, remote_ack = 1'h0, not_ready = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic [15:0] flag_eq, internal_flag_output, user_flags = 16'hA5C0;
  logic [4:0] relay_eq, relay_equation_state, user_relays = 5'h15;
  logic wb_ack_o, all_classes, warning_alarm, shutdown_alarm;
  logic centralized_alarm, new_alarm, horn, relay1_drive, irq;
  logic check_sync_active, permissive_sync_active, run_sync_active;
  logic remote_ack_request, automatic_mode_request;
  logic manual_mode_request, keypad_lock_active;
  int failures = 0, check_count = 0, n;
  // ==========
  // instances
  acsv_top #(.TICK_CYC(4)) dut (.*);
  acsv_eq_model eqm (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (k >= 20) begin
      failures++;
      results();
    end
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic trig(input int c);
    class_trigger <= 6'(1 << c);
    @(posedge clk);
    class_trigger <= 6'h00;
  endtask
  // ==========
  // sequence
  initial begin
    wait_n(2);
    arst_n <= 1'h1;
    bus(1'h0, ACSV_REG_HORN, 32'h0000_0000);
    chk(q, 32'h0000_00B4);
    bus(1'h1, 8'h14, 32'hFFFF_FFFF);
    bus(1'h0, 8'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // value 3 is refused, so run mode must survive it
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, ACSV_REG_CTRL, 32'(m));
      wait_n(2);
      chk(32'({run_sync_active, permissive_sync_active,
        check_sync_active}), 32'(1 << (m == 3 ? 2 : m)));
    end
    bus(1'h1, ACSV_REG_CTRL, 32'h0000_002E);
    wait_n(2);
    chk(32'({keypad_lock_active, manual_mode_request, automatic_mode_request,
      remote_ack_request}), 32'h0000_000B);
    bus(1'h1, ACSV_REG_CTRL, 32'h0000_003E);
    wait_n(2);
    chk(32'({keypad_lock_active, manual_mode_request, automatic_mode_request,
      remote_ack_request}), 32'h0000_000D);
    for (int i = 0; i < 6; i++) begin
      class_active <= (i % 2) ? 6'h00 : 6'(1 << i);
      class_latched <= (i % 2) ? 6'(1 << i) : 6'h00;
      wait_n(2);
      chk(32'(alarm_class), 32'(1 << i));
      chk(32'({centralized_alarm, shutdown_alarm, warning_alarm, all_classes}),
        {28'h000_0000, i > 0, i > 1, i < 2, 1'h1});
    end
    class_active <= 6'h01;
    class_latched <= 6'h00;
    wait_n(4);
    chk(32'(internal_flag_output), 32'h0000_A5C3);
    chk(32'(relay_equation_state), 32'h0000_0015);
    chk(32'(relay1_drive), 32'h0000_0001);
    not_ready <= 1'h1;
    class_active <= 6'h00;
    wait_n(2);
    chk(32'(relay1_drive), 32'h0000_0000);
    bus(1'h1, ACSV_REG_HORN, 32'h0000_0003);
    bus(1'h1, ACSV_REG_MASK, 32'h0000_0007);
    bus(1'h0, ACSV_REG_IRQ, 32'h0000_0000);
    trig(2);
    wait_n(2);
    chk(32'({new_alarm, horn, irq}), 32'h0000_0007);
    n = 0;
    while (horn === 1'h1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > 3 && n < 14), 32'h0000_0001);
    chk(32'(new_alarm), 32'h0000_0001);
    bus(1'h0, ACSV_REG_IRQ, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    wait_n(2);
    chk(32'(irq), 32'h0000_0000);
    // without a reload the first horn would be over by now
    trig(1);
    wait_n(6);
    trig(1);
    wait_n(7);
    chk(32'(horn), 32'h0000_0001);
    panel_ack <= 1'h1;
    wait_n(1);
    panel_ack <= 1'h0;
    wait_n(2);
    chk(32'(new_alarm), 32'h0000_0001);
    remote_ack <= 1'h1;
    wait_n(1);
    remote_ack <= 1'h0;
    wait_n(2);
    chk(32'(new_alarm), 32'h0000_0000);
    bus(1'h0, ACSV_REG_IRQ, 32'h0000_0000);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    bus(1'h1, ACSV_REG_MASK, 32'h0000_0000);
    trig(0);
    wait_n(3);
    chk(32'(irq), 32'h0000_0000);
    bus(1'h1, ACSV_REG_MASK, 32'h0000_0001);
    wait_n(2);
    chk(32'(irq), 32'h0000_0001);
    bus(1'h1, ACSV_REG_CTRL, 32'h0000_0076);
    wait_n(2);
    chk(32'(new_alarm), 32'h0000_0000);
    bus(1'h0, ACSV_REG_IRQ, 32'h0000_0000);
    wait_n(2);
    chk(32'(irq), 32'h0000_0000);
    results();
  end
endmodule
